/* File: hdl/plc_cfg.svh */
// plc_cfg.svh: offsets, field positions and reset values of the loop config bank
// assumes: included by its bare name by the decoder, the bank, the checker and the bench
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH

// register byte addresses on the serial control port
`define PLC_ADDR_W          10
`define PLC_OFS_ZERO_RES    10'h01D
`define PLC_OFS_PUMP_CUR    10'h0F0
`define PLC_OFS_FB_DIV      10'h0F1
`define PLC_OFS_LOOP_CTRL   10'h0F2

// input loop zero resistor field
`define PLC_ZR_MSB          3
`define PLC_ZR_LSB          0
`define PLC_ZR_MASK         8'h0F

// feedback divider fields
`define PLC_FB_A_MSB        7
`define PLC_FB_A_LSB        6
`define PLC_FB_B_MSB        5
`define PLC_FB_B_LSB        0

// output loop control fields
`define PLC_CTL_LD_PD       7
`define PLC_CTL_RSVD        6
`define PLC_CTL_DBL         5
`define PLC_CTL_ABL_OVR     4
`define PLC_CTL_ABL_MSB     3
`define PLC_CTL_ABL_LSB     2
`define PLC_CTL_CP_MSB      1
`define PLC_CTL_CP_LSB      0
`define PLC_CTL_MASK        8'hBF

// reset values
`define PLC_RST_ZERO_RES    8'h00
`define PLC_RST_PUMP_CUR    8'h00
`define PLC_RST_FB_DIV      8'h07
`define PLC_RST_LOOP_CTRL   8'h0B
`define PLC_RST_FB_RATIO    8'h1C

// forced antibacklash code while the override is clear, loaded code when it rises
`define PLC_ABL_FORCED      2'h2
`define PLC_ABL_LOADED      2'h0

`endif

/* File: hdl/plc_pkg.sv */
// plc_pkg.sv: types shared by the loop config bank and its decoder
// assumes: nothing beyond a SystemVerilog compiler
`default_nettype none
package plc_pkg;

  // input loop zero resistor selection
  typedef enum logic [2:0] {
    PLC_RZ_883K,
    PLC_RZ_677K,
    PLC_RZ_341K,
    PLC_RZ_135K,
    PLC_RZ_10K,
    PLC_RZ_EXT
  } plc_rzero_t;

  // antibacklash pulse width
  typedef enum logic [1:0] {
    PLC_ABL_MIN,
    PLC_ABL_LOW,
    PLC_ABL_HIGH,
    PLC_ABL_MAX
  } plc_abl_t;

  // charge pump mode
  typedef enum logic [1:0] {
    PLC_CP_TRISTATE,
    PLC_CP_PUMP_UP,
    PLC_CP_PUMP_DOWN,
    PLC_CP_NORMAL
  } plc_cp_mode_t;

endpackage
`default_nettype wire

/* File: hdl/plc_dec_if.sv */
// plc_dec_if.sv: raw register bytes out to the decoder, decoded settings back
// assumes: both ends run on the same clock; signals are plain combinational wires
`timescale 1ns/1ns
`default_nettype none
interface plc_dec_if;
  logic [7:0]             zero_res;
  logic [7:0]             fb_div;
  logic [7:0]             loop_ctrl;
  plc_pkg::plc_rzero_t    rzero;
  logic [7:0]             fb_n;
  logic                   fb_bad;
  plc_pkg::plc_abl_t      abl;
  plc_pkg::plc_cp_mode_t  cp_mode;

  modport bank (output zero_res, fb_div, loop_ctrl, input rzero, fb_n, fb_bad, abl, cp_mode);
  modport dec  (input zero_res, fb_div, loop_ctrl, output rzero, fb_n, fb_bad, abl, cp_mode);
endinterface
`default_nettype wire

/* File: hdl/plc_dec.sv */
// plc_dec.sv: combinational decode of the stored bytes into loop settings
// assumes: bytes come straight from the register bank flops
`timescale 1ns/1ns
`default_nettype none
`include "plc_cfg.svh"
module plc_dec
(
  // register side
  plc_dec_if.dec  d
);

  logic [3:0] zr_code;
  logic [1:0] fb_a;
  logic [5:0] fb_b;
  logic       abl_ovr;
  logic [1:0] abl_code;
  logic [1:0] abl_eff;

  // zero resistor code to selection; codes 1000 and above taken as external
  assign zr_code = d.zero_res[`PLC_ZR_MSB:`PLC_ZR_LSB];
  assign d.rzero = (zr_code == 4'h0) ? plc_pkg::PLC_RZ_883K :
                   (zr_code == 4'h1) ? plc_pkg::PLC_RZ_677K :
                   (zr_code == 4'h2) ? plc_pkg::PLC_RZ_341K :
                   (zr_code == 4'h3) ? plc_pkg::PLC_RZ_135K :
                   (zr_code[3] == 1'b0) ? plc_pkg::PLC_RZ_10K :
                   plc_pkg::PLC_RZ_EXT;

  // feedback ratio four times b plus a
  assign fb_a   = d.fb_div[`PLC_FB_A_MSB:`PLC_FB_A_LSB];
  assign fb_b   = d.fb_div[`PLC_FB_B_MSB:`PLC_FB_B_LSB];
  assign d.fb_n = {fb_b, fb_a};

  // flag pairs outside the permitted set
  assign d.fb_bad = (fb_b < 6'h04) ||
                    ((fb_b == 6'h04) && (fb_a > 2'h1)) ||
                    (((fb_b == 6'h05) || (fb_b == 6'h06)) && (fb_a == 2'h3));

  // antibacklash width forced high unless overridden
  assign abl_ovr  = d.loop_ctrl[`PLC_CTL_ABL_OVR];
  assign abl_code = d.loop_ctrl[`PLC_CTL_ABL_MSB:`PLC_CTL_ABL_LSB];
  assign abl_eff  = abl_ovr ? abl_code : `PLC_ABL_FORCED;
  assign d.abl    = plc_pkg::plc_abl_t'(abl_eff);

  // pump mode straight from its field
  assign d.cp_mode = plc_pkg::plc_cp_mode_t'(d.loop_ctrl[`PLC_CTL_CP_MSB:`PLC_CTL_CP_LSB]);

endmodule
`default_nettype wire

/* File: hdl/plc_bank.sv */
// plc_bank.sv: configuration register bank of the two loops of a clock cleaner
// assumes: the serial control port presents one byte access per strobe, in the clock domain
//
// Contract
// - zero resistor code picks one of six resistors
// - byte sets output loop pump current magnitude
// - divider is four times B plus A
// - control bit 7 powers down lock detector
// - control bit 5 doubles the reference frequency
// - override clear forces high antibacklash period
// - override rising loads code 00 into width
// - width codes minimum, low, high, maximum
// - pump mode tristate, up, down, normal; reset normal
`timescale 1ns/1ns
`default_nettype none
`include "plc_cfg.svh"
module plc_bank
(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  // register access from the serial control port
  input  wire logic [`PLC_ADDR_W-1:0]      reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [7:0]                  reg_wdata,
  output logic      [7:0]                  reg_rdata,
  output logic                             reg_rvalid,
  // input loop settings
  output var plc_pkg::plc_rzero_t          in_zero_res,
  // output loop settings
  output logic      [7:0]                  out_pump_current,
  output logic      [1:0]                  out_fb_a,
  output logic      [5:0]                  out_fb_b,
  output logic      [7:0]                  out_fb_ratio,
  output logic                             out_fb_illegal,
  output logic                             out_lock_det_pd,
  output logic                             out_ref_double,
  output var plc_pkg::plc_abl_t            out_abl_width,
  output var plc_pkg::plc_cp_mode_t        out_pump_mode
);

  logic [7:0]                zero_res_q;
  logic [7:0]                zero_res_d;
  logic [7:0]                pump_cur_q;
  logic [7:0]                pump_cur_d;
  logic [7:0]                fb_div_q;
  logic [7:0]                fb_div_d;
  logic [7:0]                loop_ctrl_q;
  logic [7:0]                loop_ctrl_d;
  logic [7:0]                rdata_q;
  logic [7:0]                rdata_d;
  logic                      rvalid_q;
  plc_pkg::plc_rzero_t       rzero_q;
  logic [7:0]                fb_n_q;
  logic                      fb_bad_q;
  plc_pkg::plc_abl_t         abl_q;
  plc_pkg::plc_cp_mode_t     cp_mode_q;

  logic                      hit_zero_res;
  logic                      hit_pump_cur;
  logic                      hit_fb_div;
  logic                      hit_loop_ctrl;
  logic                      abl_ovr_rise;
  logic [7:0]                ctrl_wr_val;
  logic                      hit_mapped;
  logic                      wr_zero_res;
  logic                      wr_pump_cur;
  logic                      wr_fb_div;
  logic                      wr_loop_ctrl;
  logic [1:0]                fb_a_fld;
  logic [5:0]                fb_b_fld;
  logic                      ld_pd_fld;
  logic                      dbl_fld;

  plc_dec_if                 dec_bus ();

  // match of the bus address against one register offset
  function automatic logic addr_hit(logic [`PLC_ADDR_W-1:0] addr, logic [`PLC_ADDR_W-1:0] ofs);
    return (addr == ofs);
  endfunction

  // control byte as stored: reserved bit cleared, width reloaded when the override rises
  function automatic logic [7:0] ctrl_store(logic [7:0] wdata, logic reload);
    logic [7:0] val;
    val = wdata & `PLC_CTL_MASK;
    if (reload)
    begin
      val[`PLC_CTL_ABL_MSB:`PLC_CTL_ABL_LSB] = `PLC_ABL_LOADED;
    end
    return val;
  endfunction

  // address decode
  assign hit_zero_res  = addr_hit(reg_addr, `PLC_OFS_ZERO_RES);
  assign hit_pump_cur  = addr_hit(reg_addr, `PLC_OFS_PUMP_CUR);
  assign hit_fb_div    = addr_hit(reg_addr, `PLC_OFS_FB_DIV);
  assign hit_loop_ctrl = addr_hit(reg_addr, `PLC_OFS_LOOP_CTRL);
  assign hit_mapped    = hit_zero_res | hit_pump_cur | hit_fb_div | hit_loop_ctrl;

  // write enables, one per register; unmapped writes fall through
  assign wr_zero_res  = reg_wr & hit_zero_res;
  assign wr_pump_cur  = reg_wr & hit_pump_cur;
  assign wr_fb_div    = reg_wr & hit_fb_div;
  assign wr_loop_ctrl = reg_wr & hit_loop_ctrl;

  // override going from clear to set on this write
  assign abl_ovr_rise = reg_wdata[`PLC_CTL_ABL_OVR] & ~loop_ctrl_q[`PLC_CTL_ABL_OVR];

  // control byte as this write would store it
  assign ctrl_wr_val = ctrl_store(reg_wdata, abl_ovr_rise);

  // next register values
  assign zero_res_d  = wr_zero_res ? (reg_wdata & `PLC_ZR_MASK) : zero_res_q;
  assign pump_cur_d  = wr_pump_cur ? reg_wdata : pump_cur_q;
  assign fb_div_d    = wr_fb_div ? reg_wdata : fb_div_q;
  assign loop_ctrl_d = wr_loop_ctrl ? ctrl_wr_val : loop_ctrl_q;

  // read mux; unmapped addresses read zero
  assign rdata_d = !reg_rd       ? rdata_q :
                   !hit_mapped   ? 8'h00 :
                   hit_zero_res  ? zero_res_q :
                   hit_pump_cur  ? pump_cur_q :
                   hit_fb_div    ? fb_div_q :
                   loop_ctrl_q;

  // raw bytes to the decoder
  assign dec_bus.zero_res  = zero_res_q;
  assign dec_bus.fb_div    = fb_div_q;
  assign dec_bus.loop_ctrl = loop_ctrl_q;

  plc_dec u_dec
  (
    .d (dec_bus.dec)
  );

  // configuration registers
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      zero_res_q  <= `PLC_RST_ZERO_RES;
      pump_cur_q  <= `PLC_RST_PUMP_CUR;
      fb_div_q    <= `PLC_RST_FB_DIV;
      loop_ctrl_q <= `PLC_RST_LOOP_CTRL;
    end
    else
    begin
      zero_res_q  <= zero_res_d;
      pump_cur_q  <= pump_cur_d;
      fb_div_q    <= fb_div_d;
      loop_ctrl_q <= loop_ctrl_d;
    end
  end

  // read data, held until the next read
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // read answer strobe, one cycle after each read
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= reg_rd;
    end
  end

  // decoded settings held in flops for the analog side
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      rzero_q   <= plc_pkg::PLC_RZ_883K;
      fb_n_q    <= `PLC_RST_FB_RATIO;
      fb_bad_q  <= 1'b0;
      abl_q     <= plc_pkg::PLC_ABL_HIGH;
      cp_mode_q <= plc_pkg::PLC_CP_NORMAL;
    end
    else
    begin
      rzero_q   <= dec_bus.rzero;
      fb_n_q    <= dec_bus.fb_n;
      fb_bad_q  <= dec_bus.fb_bad;
      abl_q     <= dec_bus.abl;
      cp_mode_q <= dec_bus.cp_mode;
    end
  end

  // direct fields of the stored bytes
  assign fb_a_fld  = fb_div_q[`PLC_FB_A_MSB:`PLC_FB_A_LSB];
  assign fb_b_fld  = fb_div_q[`PLC_FB_B_MSB:`PLC_FB_B_LSB];
  assign ld_pd_fld = loop_ctrl_q[`PLC_CTL_LD_PD];
  assign dbl_fld   = loop_ctrl_q[`PLC_CTL_DBL];

  // outputs
  assign reg_rdata        = rdata_q;
  assign reg_rvalid       = rvalid_q;
  assign in_zero_res      = rzero_q;
  assign out_pump_current = pump_cur_q;
  assign out_fb_a         = fb_a_fld;
  assign out_fb_b         = fb_b_fld;
  assign out_fb_ratio     = fb_n_q;
  assign out_fb_illegal   = fb_bad_q;
  assign out_lock_det_pd  = ld_pd_fld;
  assign out_ref_double   = dbl_fld;
  assign out_abl_width    = abl_q;
  assign out_pump_mode    = cp_mode_q;

endmodule
`default_nettype wire

/* File: tb/plc_bank_sva.sv */
// plc_bank_sva.sv: port assertions of the loop config bank
// assumes: bound to plc_bank from the bench top file
`timescale 1ns/1ns
`default_nettype none
`include "plc_cfg.svh"
module plc_chk
(
  // clock and reset
  input wire logic                        clock,
  input wire logic                        rst_b,
  // register access
  input wire logic [`PLC_ADDR_W-1:0]      reg_addr,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [7:0]                  reg_wdata,
  input wire logic                        reg_rvalid,
  // loop settings
  input wire logic [7:0]                  out_pump_current,
  input wire logic [1:0]                  out_fb_a,
  input wire logic [5:0]                  out_fb_b,
  input wire logic [7:0]                  out_fb_ratio,
  input wire logic                        out_fb_illegal,
  input wire logic                        out_lock_det_pd,
  input wire logic                        out_ref_double,
  input wire plc_pkg::plc_abl_t           out_abl_width,
  input wire plc_pkg::plc_cp_mode_t       out_pump_mode
);
  logic       ovr_q;
  logic [1:0] up_q;
  // write strobes of the pump current, divider and control registers
  wire wr_pc  = reg_wr && reg_addr == `PLC_OFS_PUMP_CUR;
  wire wr_fb  = reg_wr && reg_addr == `PLC_OFS_FB_DIV;
  wire wr_ctl = reg_wr && reg_addr == `PLC_OFS_LOOP_CTRL;
  // override as last written, cycles since reset, held once it reaches 3
  always_ff @(posedge clock)
  begin
    ovr_q <= !rst_b ? 1'b0 : wr_ctl ? reg_wdata[4] : ovr_q;
    up_q  <= !rst_b ? 2'h0 : up_q + {1'b0, up_q != 2'h3};
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  rd_pulse_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read answer");
  pump_cur_a: assert property (wr_pc |=> out_pump_current == $past(reg_wdata)) else $error("pump current");
  fb_fields_a: assert property (wr_fb |=> {out_fb_a, out_fb_b} == $past(reg_wdata)) else $error("fb fields");
  fb_ratio_a: assert property (up_q == 2'h3 |-> out_fb_ratio == {$past(out_fb_b), 2'h0} + $past(out_fb_a))
    else $error("fb ratio");
  lock_pd_a: assert property (wr_ctl |=> out_lock_det_pd == ($past(reg_wdata) >> 7)) else $error("lock pd");
  ref_dbl_a: assert property (wr_ctl |=> out_ref_double == (($past(reg_wdata) >> 5) & 8'h01)) else $error("dbl");
  abl_forced_a: assert property (wr_ctl && !reg_wdata[4] ##1 !wr_ctl |=> out_abl_width == plc_pkg::PLC_ABL_HIGH)
    else $error("abl not high");
  abl_loaded_a: assert property (wr_ctl && reg_wdata[4] && !ovr_q ##1 !wr_ctl |=>
    out_abl_width == plc_pkg::PLC_ABL_MIN) else $error("abl not min");
  abl_prog_a: assert property (wr_ctl && reg_wdata[4] && ovr_q ##1 !wr_ctl |=>
    out_abl_width == (($past(reg_wdata, 2) & 8'h0C) >> 2)) else $error("abl width");
  pump_mode_a: assert property (wr_ctl ##1 !wr_ctl |=> out_pump_mode == ($past(reg_wdata, 2) & 8'h03))
    else $error("pump mode");
  ovr_rise_c: cover property (wr_ctl && reg_wdata[4] && !ovr_q);
  fb_bad_c: cover property (out_fb_illegal);
  rd_ctl_c: cover property (reg_rd && reg_addr == `PLC_OFS_LOOP_CTRL);
endmodule
`default_nettype wire

/* File: tb/test_plc_bank.sv */
// test_plc_bank.sv: self-checking bench of the loop config bank
// assumes: plc_pkg, the bank and the checker compiled first
`timescale 1ns/1ns
`default_nettype none
`include "plc_cfg.svh"
module test_plc_bank;
  logic                  clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [9:0]            reg_addr = 10'h000;
  logic [7:0]            reg_wdata = 8'h00, reg_rdata, out_pump_current, out_fb_ratio, d, m [5];
  logic [5:0]            out_fb_b;
  logic [1:0]            out_fb_a;
  logic                  reg_rvalid, out_fb_illegal, out_lock_det_pd, out_ref_double;
  plc_pkg::plc_rzero_t   in_zero_res;
  plc_pkg::plc_abl_t     out_abl_width;
  plc_pkg::plc_cp_mode_t out_pump_mode;
  int                    num_errors = 0, tests_run = 0, cyc = 0, i;
  localparam logic [9:0] ADR [5] = '{`PLC_OFS_ZERO_RES, `PLC_OFS_PUMP_CUR, `PLC_OFS_FB_DIV,
    `PLC_OFS_LOOP_CTRL, 10'h0F3};
  // divider pairs, one pump current byte, then override and pump mode sequence
  localparam logic [9:0] CORN [15] = '{10'h204, 10'h244, 10'h284, 10'h2C6, 10'h2FF, 10'h203, 10'h1FF,
    10'h31C, 10'h3BC, 10'h300, 10'h301, 10'h3B2, 10'h314, 10'h318, 10'h32F};
  plc_bank i_plc_bank (.clock, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .in_zero_res, .out_pump_current, .out_fb_a, .out_fb_b, .out_fb_ratio, .out_fb_illegal,
    .out_lock_det_pd, .out_ref_double, .out_abl_width, .out_pump_mode);
  // clock and hang guard
  always #50 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out();
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] rz_exp(logic [3:0] c);
    return c[3] ? 8'h05 : c[2] ? 8'h04 : {6'h00, c[1:0]};
  endfunction
  function automatic logic ill(logic [7:0] f);
    return f[5:0] < 6'h04 || (f[5:0] == 6'h04 && f[7]) || ((f[5:0] == 6'h05 || f[5:0] == 6'h06) && f[7:6] == 2'h3);
  endfunction
  // one write, model follows the stored byte
  task automatic wr(int k, logic [7:0] v);
    reg_wr = 1'b1;
    reg_addr = ADR[k];
    reg_wdata = v;
    case (k)
      0: m[0] = v & `PLC_ZR_MASK;
      3: m[3] = {v[7], 1'b0, v[5:4], (v[4] && !m[3][4]) ? 2'h0 : v[3:2], v[1:0]};
      4: m[4] = 8'h00;
      default: m[k] = v;
    endcase
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(int k);
    reg_rd = 1'b1;
    reg_addr = ADR[k];
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    chk("rdata", m[k], reg_rdata);
    @(posedge clock);
    #1;
    chk("rvalid_low", 8'h00, {7'h00, reg_rvalid});
    chk("rdata_hold", m[k], reg_rdata);
  endtask
  task automatic check_all();
    @(posedge clock);
    #1;
    chk("zero_res", rz_exp(m[0][3:0]), 8'(in_zero_res));
    chk("pump_cur", m[1], out_pump_current);
    chk("fb_fields", m[2], {out_fb_a, out_fb_b});
    chk("fb_ratio", {m[2][5:0], 2'h0} + m[2][7:6], out_fb_ratio);
    chk("fb_illegal", {7'h00, ill(m[2])}, {7'h00, out_fb_illegal});
    chk("lock_pd", {7'h00, m[3][7]}, {7'h00, out_lock_det_pd});
    chk("ref_dbl", {7'h00, m[3][5]}, {7'h00, out_ref_double});
    chk("abl", {6'h00, m[3][4] ? m[3][3:2] : 2'h2}, 8'(out_abl_width));
    chk("pump_mode", {6'h00, m[3][1:0]}, 8'(out_pump_mode));
    for (int k = 0; k < 5; k++)
      rd(k);
  endtask
  // reset, corner cases, then random traffic
  initial
  begin
    void'($urandom(32'h65167746));
    m = '{8'h00, 8'h00, 8'h07, 8'h0B, 8'h00};
    repeat (3) @(posedge clock);
    #1;
    rst_b = 1'b1;
    @(posedge clock);
    #1;
    check_all();
    for (int c = 0; c < 16; c++)
    begin
      wr(0, 8'(c) | 8'hF0);
      check_all();
    end
    foreach (CORN[k])
    begin
      wr(int'(CORN[k][9:8]), CORN[k][7:0]);
      check_all();
    end
    for (int k = 0; k < 40; k++)
    begin
      i = $urandom_range(4);
      d = 8'($urandom);
      if (i == 3)
        d[6] = 1'b0;
      wr(i, d);
      rd(i);
      check_all();
    end
    close_out();
  end
endmodule
bind plc_bank plc_chk i_plc_chk (.clock, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rvalid,
  .out_pump_current, .out_fb_a, .out_fb_b, .out_fb_ratio, .out_fb_illegal, .out_lock_det_pd,
  .out_ref_double, .out_abl_width, .out_pump_mode);
`default_nettype wire
